// *** dcdt_consts.svh ***
// constants of the dual channel converter front end: offsets, fields, resets, timing
// assumes byte addresses on an 8-bit register address port
`ifndef DCDT_CONSTS_SVH
`define DCDT_CONSTS_SVH

// register byte offsets
`define DCDT_OFS_CTRL 8'h00
`define DCDT_OFS_SWTRIG 8'h04
`define DCDT_OFS_C1_12R 8'h08
`define DCDT_OFS_C1_12L 8'h0c
`define DCDT_OFS_C1_8R 8'h10
`define DCDT_OFS_C2_12R 8'h14
`define DCDT_OFS_C2_12L 8'h18
`define DCDT_OFS_C2_8R 8'h1c
`define DCDT_OFS_D_12R 8'h20
`define DCDT_OFS_D_12L 8'h24
`define DCDT_OFS_D_8R 8'h28
`define DCDT_OFS_C1_CODE 8'h2c
`define DCDT_OFS_C2_CODE 8'h30

// control layout: each channel owns a 16-bit half, 13 bits used
`define DCDT_CH_STRIDE 16
`define DCDT_CH_BITS 13
`define DCDT_CTRL_MASK 32'h1fff1fff
`define DCDT_CTRL_RST 32'h0000_0000

// trigger source codes
`define DCDT_SRC_TMR_LAST 3'h4
`define DCDT_SRC_EXT 3'h6
`define DCDT_SRC_SW 3'h7

// mask/amplitude code at which the generator saturates
`define DCDT_MAMP_SAT 4'hb
`define DCDT_FULL 12'hfff

// noise register seed and feedback taps
`define DCDT_LFSR_SEED 12'haaa
`define DCDT_LFSR_TAPS 12'h829

// load latencies in clock cycles after the cause
`define DCDT_LAT_HW 3
`define DCDT_LAT_SW 1

`endif

// *** dcdt_pkg.sv ***
// types shared by the dual channel converter front end
// assumes nothing of its surroundings
package dcdt_pkg;

	// per-channel control half, lsb first: enable, buffer off, trigger enable, ...
	typedef struct packed {
		logic dma;
		logic [3:0] mamp;
		logic [1:0] wave;
		logic [2:0] src;
		logic trgen;
		logic bufoff;
		logic en;
	} dcdt_chcfg_type;

	// waveform generator modes, taken from the 2-bit field
	typedef enum logic [1:0] {
		DCDT_WAVE_OFF = 2'h0,
		DCDT_WAVE_NOISE = 2'h1,
		DCDT_WAVE_TRI = 2'h2,
		DCDT_WAVE_TRI2 = 2'h3
	} dcdt_wave_type;

endpackage

// *** dcdt_core.sv ***
// dual channel converter front end: holding registers, output codes, triggers, waves
// assumes triggers are one-cycle pulses synchronous to CLK; one register access per cycle
//
// Operation
// [RQ1] output codes are never written by software, only loaded from holding values
// [RQ2] trigger disabled: written holding value reaches output one cycle after write
// [RQ3] timer or external line trigger: output loaded three cycles after trigger
// [RQ4] software trigger: output loaded one cycle after trigger command
// [RQ5] each channel offers timer, external line and software triggers
// [RQ6] output code is unsigned 12 bit, 4095 full scale, zero lowest
// [RQ7] single writes: 12-bit right 11:0, left 15:4, 8-bit right 7:0
// [RQ8] dual writes: right 11:0/27:16, left 15:4/31:20, 8-bit in 15:0
// [RQ9] one dual write updates both channel holding values together
// [RQ10] both triggers off: dual write loads both outputs together next cycle
// [RQ11] independent mode: software picks distinct sources, each loads on its own
// [RQ12] synchronous mode: software picks same source, both load together
// [RQ13] each channel makes noise or triangle with its own mask or amplitude
// [RQ14] channels are independent; one or both may update
// [RQ15] thirteen offsets decoded from 0x00 to 0x30
// [RQ16] source 000..100 timer events, 110 external line, 111 software
// [RQ17] waveform field 00 off, 1x triangle, 01 noise
// [RQ18] mask code n unmasks bits n..0, amplitude 2^(n+1)-1, saturating at 1011
// [RQ19] 8-bit data lands in code bits 11:4, low bits zero
// [RQ20] generation adds wave to holding value on each trigger, limited to 12 bits
`timescale 1ns/1ns
`default_nettype none
`include "dcdt_consts.svh"

module dcdt_core #(
	parameter int NCH = 2,
	parameter int NTMR = 5
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// trigger pulses
	input wire logic [NTMR-1:0] TMR_TRIG,
	input wire logic EXT_LINE,
	// converter side
	output logic [11:0] CH1_CODE,
	output logic [11:0] CH2_CODE,
	output logic [NCH-1:0] CH_ENABLE,
	output logic [NCH-1:0] CH_BUF_OFF,
	output logic [NCH-1:0] CH_DMA_EN
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] rdata_q, rdata_d;
	logic [11:0] hold_q [NCH], hold_d [NCH];
	logic [11:0] code_q [NCH], code_d [NCH];
	logic [11:0] lfsr_q [NCH], lfsr_d [NCH];
	logic [11:0] tri_q [NCH], tri_d [NCH];
	logic up_q [NCH], up_d [NCH];
	logic wpend_q [NCH], wpend_d [NCH];
	logic spend_q [NCH], spend_d [NCH];
	logic [2:0] hdly_q [NCH], hdly_d [NCH];

	// per-channel decode results
	logic hold_we [NCH];
	logic [11:0] hold_val [NCH];
	logic ld [NCH];
	dcdt_pkg::dcdt_chcfg_type cfg [NCH];

	// ----------------------------------------------------------------
	// register write decode
	// ----------------------------------------------------------------
	// one dual write fills both holding values in the same edge
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			hold_we[c] = 1'b0;
			hold_val[c] = 12'h000;
		end
		if (WR) begin
			unique case (ADDR)
				`DCDT_OFS_C1_12R: begin
					hold_we[0] = 1'b1; // [RQ7]
					hold_val[0] = WDATA[11:0];
				end
				`DCDT_OFS_C1_12L: begin
					hold_we[0] = 1'b1; // [RQ7]
					hold_val[0] = WDATA[15:4];
				end
				`DCDT_OFS_C1_8R: begin
					hold_we[0] = 1'b1; // [RQ19]
					hold_val[0] = {WDATA[7:0], 4'h0};
				end
				`DCDT_OFS_C2_12R: begin
					hold_we[1] = 1'b1;
					hold_val[1] = WDATA[11:0];
				end
				`DCDT_OFS_C2_12L: begin
					hold_we[1] = 1'b1;
					hold_val[1] = WDATA[15:4];
				end
				`DCDT_OFS_C2_8R: begin
					hold_we[1] = 1'b1;
					hold_val[1] = {WDATA[7:0], 4'h0};
				end
				`DCDT_OFS_D_12R: begin
					hold_we[0] = 1'b1; // [RQ8] [RQ9]
					hold_we[1] = 1'b1;
					hold_val[0] = WDATA[11:0];
					hold_val[1] = WDATA[27:16];
				end
				`DCDT_OFS_D_12L: begin
					hold_we[0] = 1'b1; // [RQ8] [RQ9]
					hold_we[1] = 1'b1;
					hold_val[0] = WDATA[15:4];
					hold_val[1] = WDATA[31:20];
				end
				`DCDT_OFS_D_8R: begin
					hold_we[0] = 1'b1; // [RQ8] [RQ19]
					hold_we[1] = 1'b1;
					hold_val[0] = {WDATA[7:0], 4'h0};
					hold_val[1] = {WDATA[15:8], 4'h0};
				end
				default: begin
				end
			endcase
		end
	end

	// control register; reserved bits never store
	always_comb begin
		ctrl_d = ctrl_q;
		if (WR && ADDR == `DCDT_OFS_CTRL) begin
			ctrl_d = WDATA & `DCDT_CTRL_MASK;
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	// data stands for one cycle only; unmapped and write-only read zero [RQ15]
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (RD) begin
			unique case (ADDR)
				`DCDT_OFS_CTRL: rdata_d = ctrl_q;
				`DCDT_OFS_C1_12R: rdata_d = {20'h00000, hold_q[0]};
				`DCDT_OFS_C1_12L: rdata_d = {16'h0000, hold_q[0], 4'h0};
				`DCDT_OFS_C1_8R: rdata_d = {24'h000000, hold_q[0][11:4]};
				`DCDT_OFS_C2_12R: rdata_d = {20'h00000, hold_q[1]};
				`DCDT_OFS_C2_12L: rdata_d = {16'h0000, hold_q[1], 4'h0};
				`DCDT_OFS_C2_8R: rdata_d = {24'h000000, hold_q[1][11:4]};
				`DCDT_OFS_D_12R: rdata_d = {4'h0, hold_q[1], 4'h0, hold_q[0]};
				`DCDT_OFS_D_12L: rdata_d = {hold_q[1], 4'h0, hold_q[0], 4'h0};
				`DCDT_OFS_D_8R: rdata_d = {16'h0000, hold_q[1][11:4], hold_q[0][11:4]};
				`DCDT_OFS_C1_CODE: rdata_d = {20'h00000, code_q[0]}; // [RQ6]
				`DCDT_OFS_C2_CODE: rdata_d = {20'h00000, code_q[1]};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// channel datapath
	// ----------------------------------------------------------------
	// both channels share one loop but no state crosses between them [RQ14]
	always_comb begin
		logic hw_trig;
		logic gen;
		logic [11:0] amp;
		logic [12:0] amp13;
		logic [11:0] addv;
		logic [12:0] sum;
		hw_trig = 1'b0;
		gen = 1'b0;
		amp = 12'h000;
		amp13 = 13'h0000;
		addv = 12'h000;
		sum = 13'h0000;
		for (int c = 0; c < NCH; c++) begin
			cfg[c] = dcdt_pkg::dcdt_chcfg_type'(ctrl_q[c*`DCDT_CH_STRIDE +: `DCDT_CH_BITS]);
			// source select: timers, external line, or nothing [RQ5] [RQ16]
			if (cfg[c].src <= `DCDT_SRC_TMR_LAST) begin
				hw_trig = TMR_TRIG[cfg[c].src];
			end else if (cfg[c].src == `DCDT_SRC_EXT) begin
				hw_trig = EXT_LINE;
			end else begin
				hw_trig = 1'b0;
			end
			hold_d[c] = hold_we[c] ? hold_val[c] : hold_q[c];
			wpend_d[c] = hold_we[c]; // [RQ2]
			spend_d[c] = WR && ADDR == `DCDT_OFS_SWTRIG && WDATA[c]; // [RQ4]
			// pipeline so a hardware trigger loads on the third edge [RQ3]
			hdly_d[c] = {hdly_q[c][1:0], hw_trig};
			// load condition; the output code has no other way in [RQ1]
			if (!cfg[c].trgen) begin
				ld[c] = wpend_q[c]; // [RQ2] [RQ10]
			end else if (cfg[c].src == `DCDT_SRC_SW) begin
				ld[c] = spend_q[c]; // [RQ4]
			end else begin
				ld[c] = hdly_q[c][2]; // [RQ3]
			end
			gen = ld[c] && cfg[c].trgen && cfg[c].wave != dcdt_pkg::DCDT_WAVE_OFF;
			// amplitude doubles as noise mask; saturate at full 12 bits [RQ18]
			amp13 = (13'h0002 << cfg[c].mamp) - 13'h0001;
			amp = (cfg[c].mamp >= `DCDT_MAMP_SAT) ? `DCDT_FULL : amp13[11:0];
			lfsr_d[c] = lfsr_q[c];
			tri_d[c] = tri_q[c];
			up_d[c] = up_q[c];
			if (gen && cfg[c].wave[1]) begin
				// triangle turns at the amplitude and at zero [RQ13] [RQ17]
				if (up_q[c] && tri_q[c] < amp) begin
					tri_d[c] = tri_q[c] + 12'h001;
				end else if (up_q[c]) begin
					up_d[c] = 1'b0;
					tri_d[c] = tri_q[c] - 12'h001;
				end else if (tri_q[c] != 12'h000) begin
					tri_d[c] = tri_q[c] - 12'h001;
				end else begin
					up_d[c] = 1'b1;
					tri_d[c] = tri_q[c] + 12'h001;
				end
			end else if (gen) begin
				// tap on bit 11 keeps a nonzero register nonzero [RQ13] [RQ17]
				lfsr_d[c] = {lfsr_q[c][10:0], ^(lfsr_q[c] & `DCDT_LFSR_TAPS)};
			end
			addv = cfg[c].wave[1] ? tri_d[c] : (lfsr_d[c] & amp);
			sum = {1'b0, hold_q[c]} + {1'b0, addv};
			// adding past full scale clips instead of wrapping [RQ20] [RQ6]
			if (gen) begin
				code_d[c] = sum[12] ? `DCDT_FULL : sum[11:0];
			end else if (ld[c]) begin
				code_d[c] = hold_q[c];
			end else begin
				code_d[c] = code_q[c];
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// all state registered here; reset takes constants only
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_q <= `DCDT_CTRL_RST;
			rdata_q <= 32'h0000_0000;
			for (int c = 0; c < NCH; c++) begin
				hold_q[c] <= 12'h000;
				code_q[c] <= 12'h000;
				lfsr_q[c] <= `DCDT_LFSR_SEED;
				tri_q[c] <= 12'h000;
				up_q[c] <= 1'b1;
				wpend_q[c] <= 1'b0;
				spend_q[c] <= 1'b0;
				hdly_q[c] <= 3'h0;
			end
		end else begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			for (int c = 0; c < NCH; c++) begin
				hold_q[c] <= hold_d[c];
				code_q[c] <= code_d[c];
				lfsr_q[c] <= lfsr_d[c];
				tri_q[c] <= tri_d[c];
				up_q[c] <= up_d[c];
				wpend_q[c] <= wpend_d[c];
				spend_q[c] <= spend_d[c];
				hdly_q[c] <= hdly_d[c];
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// enables and flags come straight from the control flops
	assign RDATA = rdata_q;
	assign CH1_CODE = code_q[0];
	assign CH2_CODE = code_q[1];
	for (genvar g = 0; g < NCH; g++) begin : g_flags
		assign CH_ENABLE[g] = cfg[g].en;
		assign CH_BUF_OFF[g] = cfg[g].bufoff;
		assign CH_DMA_EN[g] = cfg[g].dma;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// per-channel timing of loads
	for (genvar g = 0; g < NCH; g++) begin : g_chk
		auto_load_a: assert property ( // [RQ2]
			hold_we[g] && !cfg[g].trgen ##1 !cfg[g].trgen |=> code_q[g] == $past(hold_q[g])
			|| cfg[g].trgen)
			else $error("auto load missed");
		hw_delay_a: assert property ( // [RQ3]
			cfg[g].trgen && cfg[g].src != `DCDT_SRC_SW && hdly_d[g][0]
			##1 (cfg[g].trgen && cfg[g].src != `DCDT_SRC_SW)[*3] |-> ld[g])
			else $error("hardware trigger load not on third edge");
		sw_load_a: assert property ( // [RQ4]
			spend_d[g] && cfg[g].trgen && cfg[g].src == `DCDT_SRC_SW
			##1 cfg[g].trgen && cfg[g].src == `DCDT_SRC_SW |-> ld[g])
			else $error("software trigger load missed");
		no_direct_a: assert property ( // [RQ1]
			code_q[g] != $past(code_q[g]) |-> $past(ld[g]))
			else $error("output code changed without a load");
		plain_load_a: assert property ( // [RQ20]
			ld[g] && cfg[g].wave == dcdt_pkg::DCDT_WAVE_OFF |=> code_q[g] == $past(hold_q[g]))
			else $error("plain load did not copy holding value");
		// generator results stay within their limits; trigger gating holds writes back
		sat_clip_a: assert property ( // [RQ20]
			ld[g] && cfg[g].trgen && cfg[g].wave != dcdt_pkg::DCDT_WAVE_OFF
			|=> code_q[g] >= $past(hold_q[g]))
			else $error("generated code wrapped below holding value");
		noise_mask_a: assert property ( // [RQ18]
			ld[g] && cfg[g].trgen && cfg[g].wave == dcdt_pkg::DCDT_WAVE_NOISE
			&& cfg[g].mamp == 4'h0 |=> code_q[g] == $past(hold_q[g])
			|| code_q[g] == $past(hold_q[g]) + 12'h001 || code_q[g] == `DCDT_FULL)
			else $error("noise exceeded a one-bit mask");
		gated_write_a: assert property ( // [RQ1]
			hold_we[g] && cfg[g].trgen ##1 cfg[g].trgen && !spend_q[g] && !hdly_q[g][2]
			|=> $stable(code_q[g]))
			else $error("holding write loaded while trigger enabled");
	end

	// write formats, the shared dual load and read data clearing
	dual_write_a: assert property ( // [RQ9]
		WR && ADDR == `DCDT_OFS_D_12R |=> hold_q[0] == $past(WDATA[11:0])
		&& hold_q[1] == $past(WDATA[27:16]))
		else $error("dual write did not fill both channels");
	byte_align_a: assert property ( // [RQ19]
		WR && ADDR == `DCDT_OFS_D_8R |=> hold_q[0] == {$past(WDATA[7:0]), 4'h0}
		&& hold_q[1] == {$past(WDATA[15:8]), 4'h0})
		else $error("8-bit data misplaced");
	left_align_a: assert property ( // [RQ7]
		WR && ADDR == `DCDT_OFS_C1_12L |=> hold_q[0] == $past(WDATA[15:4]))
		else $error("left aligned data misplaced");
	sync_soft_a: assert property ( // [RQ10]
		hold_we[0] && hold_we[1] && !cfg[0].trgen && !cfg[1].trgen
		|=> ld[0] && ld[1] || cfg[0].trgen || cfg[1].trgen)
		else $error("dual outputs not loaded together");
	read_once_a: assert property ( // [RQ15]
		!RD |=> RDATA == 32'h0000_0000)
		else $error("read data stood outside its cycle");

	// channel isolation, remaining formats and code reads
	ch1_isolate_a: assert property ( // [RQ14]
		WR && ADDR == `DCDT_OFS_C2_12R |=> $stable(hold_q[0]))
		else $error("channel two write disturbed channel one");
	ch2_isolate_a: assert property ( // [RQ14]
		WR && ADDR == `DCDT_OFS_C1_12R |=> $stable(hold_q[1]))
		else $error("channel one write disturbed channel two");
	ch1_byte_a: assert property ( // [RQ7]
		WR && ADDR == `DCDT_OFS_C1_8R |=> hold_q[0] == {$past(WDATA[7:0]), 4'h0})
		else $error("channel one 8-bit data misplaced");
	ch2_byte_a: assert property ( // [RQ19]
		WR && ADDR == `DCDT_OFS_C2_8R |=> hold_q[1] == {$past(WDATA[7:0]), 4'h0})
		else $error("channel two 8-bit data misplaced");
	ch2_left_a: assert property ( // [RQ7]
		WR && ADDR == `DCDT_OFS_C2_12L |=> hold_q[1] == $past(WDATA[15:4]))
		else $error("channel two left aligned data misplaced");
	dual_left_a: assert property ( // [RQ8]
		WR && ADDR == `DCDT_OFS_D_12L |=> hold_q[0] == $past(WDATA[15:4])
		&& hold_q[1] == $past(WDATA[31:20]))
		else $error("dual left aligned data misplaced");
	read_code_a: assert property ( // [RQ6]
		RD && ADDR == `DCDT_OFS_C2_CODE |=> RDATA == {20'h00000, $past(code_q[1])})
		else $error("output code read back wrongly");

endmodule

`default_nettype wire

// *** dcdt_trig_model.sv ***
// trigger source model: timer event lines and the external line, one pulse per request
// assumes requests are set by non-blocking assignment just after a rising edge
`timescale 1ns/1ns
`default_nettype none

module dcdt_trig_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request from the bench
	input wire logic fire,
	input wire logic [2:0] sel,
	// trigger lines towards the converter
	output logic [4:0] tmr_trig,
	output logic ext_line
);
	// ----------------------------------------
	// pulse generation
	// ----------------------------------------
	logic [4:0] tmr_d;
	logic [4:0] tmr_q;
	logic ext_d;
	logic ext_q;

	// only the selected line pulses, so a channel on another source must not load
	always_comb begin
		tmr_d = 5'h00;
		ext_d = 1'b0;
		if (fire && sel <= 3'h4) begin
			tmr_d = 5'h01 << sel;
		end
		if (fire && sel == 3'h6) begin
			ext_d = 1'b1;
		end
	end

	// lines move only after an edge, as a timer output would; one cycle long
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tmr_q <= 5'h00;
			ext_q <= 1'b0;
		end else begin
			tmr_q <= tmr_d;
			ext_q <= ext_d;
		end
	end

	assign tmr_trig = tmr_q;
	assign ext_line = ext_q;
endmodule
`default_nettype wire

// *** dcdt_core_bench.sv ***
// self-checking bench of the converter front end: register port, load paths, waveforms
// assumes the design files and the trigger model are compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "dcdt_consts.svh"

module dcdt_core_bench;
	// ----------------------------------------
	// signals and design
	// ----------------------------------------
	typedef struct {logic [7:0] a; logic [31:0] d; logic [11:0] c1; logic [11:0] c2;} dcdt_row_type;
	logic clk, rst, wr_s, rd_s, fire, ext_line;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] sel;
	logic [4:0] tmr_trig;
	logic [11:0] ch1_code, ch2_code, p1, p2, v;
	logic [1:0] ch_en, ch_buf, ch_dma;
	int fail_count = 0;
	int comparisons = 0;
	dcdt_row_type rows [9] = '{'{8'h08, 32'hfffff123, 12'h123, 12'h000},
		'{8'h0c, 32'h0000abc0, 12'habc, 12'h000}, '{8'h10, 32'h000000ff, 12'hff0, 12'h000},
		'{8'h14, 32'h00000456, 12'hff0, 12'h456}, '{8'h18, 32'h0000fff0, 12'hff0, 12'hfff},
		'{8'h1c, 32'h0000005a, 12'hff0, 12'h5a0}, '{8'h20, 32'h07890321, 12'h321, 12'h789},
		'{8'h24, 32'hdef01230, 12'h123, 12'hdef}, '{8'h28, 32'h0000a55a, 12'h5a0, 12'ha50}};
	logic [2:0] srcs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
	logic [2:0] wrongs [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h0};
	logic [11:0] tri_exp [5] = '{12'h101, 12'h100, 12'h101, 12'hfff, 12'hfff};

	dcdt_core u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .TMR_TRIG(tmr_trig), .EXT_LINE(ext_line), .CH1_CODE(ch1_code),
		.CH2_CODE(ch2_code), .CH_ENABLE(ch_en), .CH_BUF_OFF(ch_buf), .CH_DMA_EN(ch_dma));
	dcdt_trig_model u_trig (.clk(clk), .rst(rst), .fire(fire), .sel(sel),
		.tmr_trig(tmr_trig), .ext_line(ext_line));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// strobes last one cycle; the next access waits one edge so no signal is set twice at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk(name, rdata, exp);
	endtask

	// codes hold the old values for n settled samples and the new ones at sample n
	task automatic ldchk(input int n, input logic [11:0] o1, n1, o2, n2);
		for (int k = 0; k <= n; k++) begin
			@(negedge clk);
			chk("ch1 code", {20'h0, ch1_code}, {20'h0, k == n ? n1 : o1});
			chk("ch2 code", {20'h0, ch2_code}, {20'h0, k == n ? n2 : o2});
		end
	endtask

	task automatic trig(input logic [2:0] s);
		@(posedge clk);
		sel <= s;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask

	function automatic logic [15:0] cfg(input logic tg, input logic [2:0] s, input logic [1:0] w,
		input logic [3:0] m);
		dcdt_pkg::dcdt_chcfg_type c;
		c = '0;
		c.trgen = tg;
		c.src = s;
		c.wave = w;
		c.mamp = m;
		return {3'h0, c};
	endfunction

	task automatic results;
		if (fail_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		fail_count++;
		results();
	end

	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		fire = 1'b0;
		sel = 3'h0;
		p1 = 12'h000;
		p2 = 12'h000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("codes at reset", {8'h0, ch1_code, ch2_code}, 32'h0);
		rd(`DCDT_OFS_CTRL, 32'h0, "control at reset");
		// trigger off: every holding format lands one cycle after the write
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			ldchk(1, p1, rows[i].c1, p2, rows[i].c2);
			rd(8'h2c, {20'h0, rows[i].c1}, "ch1 code read");
			rd(8'h30, {20'h0, rows[i].c2}, "ch2 code read");
			p1 = rows[i].c1;
			p2 = rows[i].c2;
		end
		// output codes cannot be written; unmapped and command offsets read zero
		wr(8'h2c, 32'h00000777);
		wr(8'h30, 32'h00000777);
		ldchk(1, p1, p1, p2, p2);
		rd(8'h34, 32'h0, "unmapped read");
		rd(8'h04, 32'h0, "command read");
		wr(8'h00, 32'hffffffff);
		rd(8'h00, `DCDT_CTRL_MASK, "control mask");
		chk("control outputs", {26'h0, ch_dma, ch_buf, ch_en}, 32'h3f);
		// enable and DMA share one pattern, buffer off another, so a swap with buffer off shows up but not enable with DMA
		wr(8'h00, 32'h00021001);
		@(negedge clk);
		chk("control pattern", {26'h0, ch_dma, ch_buf, ch_en}, 32'h19);
		// each hardware source, with a wrong source fired first
		for (int i = 0; i < 6; i++) begin
			v = 12'h100 + 12'(i);
			wr(8'h00, {cfg(1'b1, 3'h7, 2'h0, 4'h0), cfg(1'b1, srcs[i], 2'h0, 4'h0)});
			wr(8'h08, {20'h0, v});
			ldchk(1, p1, p1, p2, p2);
			trig(wrongs[i]);
			ldchk(4, p1, p1, p2, p2);
			trig(srcs[i]);
			ldchk(4, p1, v, p2, p2);
			p1 = v;
		end
		// software command loads channel two only; channel one is on another source
		wr(8'h14, 32'h00000abc);
		wr(8'h04, 32'h00000003);
		ldchk(1, p1, p1, p2, 12'habc);
		// one external pulse loads both channels together
		wr(8'h00, {cfg(1'b1, 3'h6, 2'h0, 4'h0), cfg(1'b1, 3'h6, 2'h0, 4'h0)});
		wr(8'h20, 32'h05550666);
		trig(3'h6);
		ldchk(4, p1, 12'h666, 12'habc, 12'h555);
		p1 = 12'h666;
		p2 = 12'h555;
		// channel one triangle of amplitude one, channel two noise on one bit
		wr(8'h00, {cfg(1'b1, 3'h7, 2'h1, 4'h0), cfg(1'b1, 3'h7, 2'h2, 4'h0)});
		wr(8'h08, 32'h00000100);
		wr(8'h14, 32'h00000200);
		for (int i = 0; i < 5; i++) begin
			if (i == 3) begin
				wr(8'h08, 32'h00000fff);
			end
			wr(8'h04, 32'h00000001);
			ldchk(1, p1, tri_exp[i], p2, p2);
			p1 = tri_exp[i];
		end
		wr(8'h04, 32'h00000002);
		repeat (2) @(negedge clk);
		chk("ch2 noise", {20'h0, ch2_code}, 32'h201);
		// widest mask passes the whole next noise word onto the holding value
		wr(8'h00, {cfg(1'b1, 3'h7, 2'h1, 4'hf), cfg(1'b1, 3'h7, 2'h2, 4'h0)});
		wr(8'h04, 32'h00000002);
		repeat (2) @(negedge clk);
		chk("ch2 full noise", {20'h0, ch2_code}, 32'hcab);
		// reset in mid-run clears codes and control
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("codes after reset", {8'h0, ch1_code, ch2_code}, 32'h0);
		rd(8'h00, 32'h0, "control after reset");
		results();
	end
endmodule
`default_nettype wire
